/* dv/amb_mem_model.sv */
// Purpose: behavioural model of the byte-wide nonvolatile memory
// Assumes: pins sampled on the host clock edge
// Notes: detailed pin timing is not modelled
`timescale 1ns/1ps
`default_nettype none
module amb_mem_model
(
    input wire logic clk,
    input wire logic supply_ok,
    input wire logic [amb_pkg::ADDR_W-1:0] addr,
    input wire logic sel_n,
    input wire logic wstb_n,
    input wire logic oen_n,
    input wire logic [amb_pkg::DATA_W-1:0] bus,
    output logic [amb_pkg::DATA_W-1:0] dq,
    output logic dq_oe
);
    // full byte array, kept with no refresh and across supply loss
    logic [amb_pkg::DATA_W-1:0] store [amb_pkg::WORDS];
    // resolved bus is stored, so a floating bus writes junk like the real part
    always @(posedge clk)
    begin
        if (!sel_n && !wstb_n && supply_ok)
        begin
            store[addr] <= bus;
        end
    end
    assign dq_oe = !sel_n && !oen_n && wstb_n;
    assign dq = store[addr];
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Purpose: self-checking bench for the async memory host controller
// Assumes: short startup count, inputs driven at the falling edge
// Notes: a floating bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int STARTUP = 20;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b1;
    logic supply_ok = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [18:0] req_addr = 19'h0;
    logic [7:0] req_wdata = 8'h0;
    logic req_ready, rsp_valid, mem_ready, mem_sel_n, mem_wstb_n, mem_oen_n, mem_dq_oe, dev_oe;
    logic [7:0] rsp_rdata, mem_dq_out, dev_dq, bus;
    logic [7:0] float_pat = 8'h5a;
    logic [18:0] mem_addr;
    logic started = 1'b0;
    int mismatches = 0;
    int checks = 0;
    // contention shows as unknown so any compare on it fails
    assign bus = (dev_oe && mem_dq_oe) ? 8'hxx : dev_oe ? dev_dq : mem_dq_oe ? mem_dq_out : float_pat;
    // a released bus keeps showing the inverse of what was last driven
    always @(posedge sys_clk)
        if (dev_oe || mem_dq_oe)
            float_pat <= ~bus;
    initial forever #12.5 sys_clk = ~sys_clk;
    amb_host #(.STARTUP_CYCLES(STARTUP)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .supply_ok(supply_ok), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ready(mem_ready),
        .mem_addr(mem_addr), .mem_sel_n(mem_sel_n), .mem_wstb_n(mem_wstb_n),
        .mem_oen_n(mem_oen_n), .mem_dq_in(bus), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
    amb_mem_model u_mem (.clk(sys_clk), .supply_ok(supply_ok), .addr(mem_addr),
        .sel_n(mem_sel_n), .wstb_n(mem_wstb_n), .oen_n(mem_oen_n), .bus(bus),
        .dq(dev_dq), .dq_oe(dev_oe));
    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(negedge sys_clk)
    begin
        if (started)
        begin
            check(dev_oe & mem_dq_oe, 1'b0);
            if (mem_ready !== 1'b1)
                check({mem_sel_n, mem_wstb_n}, 2'b11);
        end
    end
    task automatic wait_ready(output int n);
        n = 0;
        while (req_ready !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        check(req_ready, 1'b1);
    endtask
    // one request; for a read, d is the byte expected back
    task automatic op(input logic wr, input logic [18:0] a, input logic [7:0] d);
        int n;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        wait_ready(n);
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
            if (n == 1)
                check({mem_sel_n, mem_wstb_n, mem_oen_n, mem_dq_oe, mem_addr},
                    wr ? {4'b0011, a} : {4'b0100, a});
            if (n == 1 && wr)
                check(mem_dq_out, d);
        end
        // counted from the cycle after the take: write ends one past the access time,
        // a read two more for the data synchroniser
        check(n, wr ? amb_pkg::ACCESS_CYC + 1 : amb_pkg::ACCESS_CYC + 3);
        check({mem_sel_n, mem_wstb_n}, 2'b11);
        if (!wr)
            check(rsp_rdata, d);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_startup();
        int n;
        check(mem_ready, 1'b0);
        wait_ready(n);
        check(n >= STARTUP, 1'b1);
        check(mem_ready, 1'b1);
    endtask
    task automatic t_rw();
        logic [18:0] a [4] = '{19'h0, 19'h7ffff, 19'h12345, 19'h0};
        logic [7:0] d [4] = '{8'ha5, 8'h3c, 8'hff, 8'h5e};
        for (int i = 0; i < 4; i++)
            op(1'b1, a[i], d[i]);
        for (int i = 1; i < 4; i++)
            op(1'b0, a[i], d[i]);
    endtask
    task automatic t_brownout();
        int n;
        req_write = 1'b1;
        req_addr = 19'h7ffff;
        req_wdata = 8'h81;
        req_valid = 1'b1;
        wait_ready(n);
        @(negedge sys_clk);
        req_valid = 1'b0;
        // supply drops before the memory sees the strobe, so the write must not land
        supply_ok = 1'b0;
        n = 0;
        repeat (10)
        begin
            @(negedge sys_clk);
            n += rsp_valid;
        end
        check(n, 0);
        check({mem_ready, req_ready}, 2'b00);
        supply_ok = 1'b1;
        wait_ready(n);
        check(n >= STARTUP, 1'b1);
        op(1'b0, 19'h7ffff, 8'h3c);
    endtask
    initial
    begin
        #(25ns * 5000);
        mismatches++;
        wrap_up();
    end
    initial
    begin
        // a real falling edge, so the async reset acts before the first clock
        #1;
        rst_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        started = 1'b1;
        t_startup();
        t_rw();
        t_brownout();
        wrap_up();
    end
endmodule
`default_nettype wire

/* rtl/amb_host.sv */
// Purpose: host controller driving an asynchronous byte-wide nonvolatile memory
// Assumes: single 40 MHz clock, memory reached through its pins only
// Notes: supply monitor input restarts the startup wait
//
// Operation
// - select and strobe low writes; host drives write data meanwhile
// - no access until 2 ms after supply reaches operating level
// - after brownout or power loss, wait full startup again
// - hold select and strobe high through reset beyond startup interval
// - write lasts only while select and strobe both low
// - strobe or select stays high at least 2 ns before falling again
`timescale 1ns/1ps
`default_nettype none
module amb_host #(
    parameter int STARTUP_CYCLES = amb_pkg::STARTUP_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [amb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [amb_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [amb_pkg::DATA_W-1:0] rsp_rdata,
    output logic mem_ready,
    output logic [amb_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_sel_n,
    output logic mem_wstb_n,
    output logic mem_oen_n,
    input wire logic [amb_pkg::DATA_W-1:0] mem_dq_in,
    output logic [amb_pkg::DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe
);
    // a zero wait would let the first access race the supply ramp
    if (STARTUP_CYCLES < 1)
    begin : g_bad_startup
        $error("startup count must be at least one cycle");
    end

    // ********************
    // reset and pin synchronisers
    // ********************
    logic rst_s1_reg, rst_s2_reg, sup_s1_reg, sup_s2_reg;
    logic [amb_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic srst_n = rst_s2_reg;
    // read data passes two flops, so a read holds enable long enough to cover them
    always_ff @(posedge sys_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            sup_s1_reg <= 1'b0;
            sup_s2_reg <= 1'b0;
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
        end
        else
        begin
            sup_s1_reg <= supply_ok;
            sup_s2_reg <= sup_s1_reg;
            dq_s1_reg <= mem_dq_in;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // ********************
    // access sequencer
    // ********************
    localparam int CW = $clog2(STARTUP_CYCLES + amb_pkg::ACCESS_CYC + 4);
    localparam logic [CW-1:0] ACC_LAST = CW'(amb_pkg::ACCESS_CYC + 2);
    localparam logic [CW-1:0] WR_LAST = CW'(amb_pkg::ACCESS_CYC);
    localparam logic [CW-1:0] HI_LAST = CW'(amb_pkg::HIGH_CYC);
    localparam logic [CW-1:0] SU_LAST = CW'(STARTUP_CYCLES);
    amb_pkg::amb_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [amb_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [amb_pkg::DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic oen_reg, oen_next, dqoe_reg, dqoe_next, rsp_reg, rsp_next;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + CW'(1);
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        oen_next = oen_reg;
        dqoe_next = dqoe_reg;
        rsp_next = 1'b0;
        case (state_reg)
            amb_pkg::AMB_ST_POWERUP:
            begin
                // select and strobe held high for the whole wait
                ctrl_next = amb_pkg::CTRL_HIGH;
                if (!sup_s2_reg)
                    cnt_next = '0;
                else if (cnt_reg >= SU_LAST)
                    state_next = amb_pkg::AMB_ST_IDLE;
            end
            amb_pkg::AMB_ST_IDLE:
            begin
                cnt_next = '0;
                if (req_valid)
                begin
                    addr_next = req_addr;
                    wdata_next = req_wdata;
                    // bit0 select, bit1 strobe; write pulls both low together
                    ctrl_next = req_write ? 2'h0 : 2'h2;
                    dqoe_next = req_write;
                    oen_next = 1'b1;
                    state_next = req_write ? amb_pkg::AMB_ST_WRITE : amb_pkg::AMB_ST_READ;
                    if (!req_write)
                    begin
                        dqoe_next = 1'b0;
                        oen_next = 1'b0;
                    end
                end
            end
            amb_pkg::AMB_ST_READ:
            begin
                if (cnt_reg >= ACC_LAST)
                begin
                    rdata_next = dq_s2_reg;
                    rsp_next = 1'b1;
                    ctrl_next = amb_pkg::CTRL_HIGH;
                    oen_next = 1'b1;
                    cnt_next = '0;
                    state_next = amb_pkg::AMB_ST_RECOVER;
                end
            end
            amb_pkg::AMB_ST_WRITE:
            begin
                if (cnt_reg >= WR_LAST)
                begin
                    // raise both at once; data held one more cycle for hold time
                    ctrl_next = amb_pkg::CTRL_HIGH;
                    rsp_next = 1'b1;
                    cnt_next = '0;
                    state_next = amb_pkg::AMB_ST_RECOVER;
                end
            end
            amb_pkg::AMB_ST_RECOVER:
            begin
                dqoe_next = 1'b0;
                if (cnt_reg >= HI_LAST)
                    state_next = amb_pkg::AMB_ST_IDLE;
            end
            default:
            begin
                state_next = amb_pkg::AMB_ST_POWERUP;
                ctrl_next = amb_pkg::CTRL_HIGH;
                oen_next = 1'b1;
                dqoe_next = 1'b0;
                cnt_next = '0;
            end
        endcase
        // brownout restarts the startup wait from any state
        if (!sup_s2_reg && state_reg != amb_pkg::AMB_ST_POWERUP)
        begin
            state_next = amb_pkg::AMB_ST_POWERUP;
            ctrl_next = amb_pkg::CTRL_HIGH;
            oen_next = 1'b1;
            dqoe_next = 1'b0;
            rsp_next = 1'b0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            state_reg <= amb_pkg::AMB_ST_POWERUP;
            cnt_reg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            ctrl_reg <= amb_pkg::CTRL_HIGH;
            oen_reg <= 1'b1;
            dqoe_reg <= 1'b0;
            rsp_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            oen_reg <= oen_next;
            dqoe_reg <= dqoe_next;
            rsp_reg <= rsp_next;
        end
    end

    // ********************
    // outputs
    // ********************
    assign req_ready = (state_reg == amb_pkg::AMB_ST_IDLE);
    assign mem_ready = (state_reg != amb_pkg::AMB_ST_POWERUP);
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;
    assign mem_addr = addr_reg;
    assign mem_sel_n = ctrl_reg[0];
    assign mem_wstb_n = ctrl_reg[1];
    assign mem_oen_n = oen_reg;
    assign mem_dq_out = wdata_reg;
    assign mem_dq_oe = dqoe_reg;

    // ********************
    // assertions
    // ********************
    a_no_contention: assert property (@(posedge sys_clk) disable iff (!srst_n)
        !(mem_dq_oe && !mem_oen_n))
        else $error("host drives data while read enable low");
    a_powerup_quiet: assert property (@(posedge sys_clk) disable iff (!srst_n)
        (state_reg == amb_pkg::AMB_ST_POWERUP) |-> (mem_sel_n && mem_wstb_n))
        else $error("select or strobe low during startup");
    a_write_data_driven: assert property (@(posedge sys_clk) disable iff (!srst_n)
        (!mem_sel_n && !mem_wstb_n) |-> mem_dq_oe)
        else $error("write strobe without driven data");
    a_write_oen_high: assert property (@(posedge sys_clk) disable iff (!srst_n)
        !mem_wstb_n |-> mem_oen_n)
        else $error("read enable low during write");
    a_high_gap: assert property (@(posedge sys_clk) disable iff (!srst_n)
        $rose(mem_sel_n) |-> mem_sel_n [*2])
        else $error("select high too briefly");
    a_brownout_stop: assert property (@(posedge sys_clk) disable iff (!srst_n)
        !sup_s2_reg |=> (state_reg == amb_pkg::AMB_ST_POWERUP) && mem_sel_n)
        else $error("access continued during brownout");
    a_read_answer: assert property (@(posedge sys_clk) disable iff (!srst_n)
        (req_ready && req_valid && !req_write && sup_s2_reg)
        |=> !mem_oen_n && !mem_sel_n && mem_wstb_n)
        else $error("read request did not start a read");
    a_read_done: assert property (@(posedge sys_clk) disable iff (!srst_n)
        $rose(rsp_valid) |-> mem_sel_n && mem_oen_n)
        else $error("read answer with memory still selected");
    c_read: cover property (@(posedge sys_clk) disable iff (!srst_n)
        rsp_valid && mem_wstb_n);
    c_write: cover property (@(posedge sys_clk) disable iff (!srst_n)
        !mem_wstb_n ##1 mem_wstb_n);
    c_brownout: cover property (@(posedge sys_clk) disable iff (!srst_n)
        mem_ready ##1 !mem_ready);
endmodule
`default_nettype wire

/* rtl/amb_pkg.sv */
// Purpose: shared constants for the byte-wide async memory host controller
// Assumes: 40 MHz system clock
// Notes: timing counts derived from printed figures
package amb_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int WORDS = 524288;
    localparam int CLK_PERIOD_PS = 25000;
    // startup interval, in microseconds
    localparam int STARTUP_US = 2000;
    localparam int STARTUP_CYC = (STARTUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // least high time of strobe and select between accesses, in picoseconds
    localparam int HIGH_MIN_PS = 2000;
    localparam int HIGH_CYC_RAW = (HIGH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HIGH_CYC = (HIGH_CYC_RAW < 1) ? 1 : HIGH_CYC_RAW;
    // access cycle time, in picoseconds
    localparam int ACCESS_PS = 35000;
    localparam int ACCESS_CYC = (ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] CTRL_HIGH = 2'h3;
    typedef enum logic [2:0]
    {
        AMB_ST_POWERUP = 3'h0,
        AMB_ST_IDLE = 3'h1,
        AMB_ST_READ = 3'h2,
        AMB_ST_WRITE = 3'h3,
        AMB_ST_RECOVER = 3'h4
    } amb_state_t;
endpackage
